// >>> rtl/sssrb_status_bank.sv
/*
 * status register bank: device, questionable, power, zeroing, standard event and mask.
 * assumes command, query and error strobes come from a parser on sys_clk; fault pins are asynchronous.
 */
`timescale 1ns/100ps
module sssrb_status_bank #(
	parameter int SLOW_CYC = sssrb_pkg::SLOW_HALF_CYC, // slow flash half period in cycles
	parameter int FAST_CYC = sssrb_pkg::FAST_HALF_CYC  // fast flash half period in cycles
) (
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	input  wire logic [3:0]                   staticFault,   // pins: no-meas, erroneous, warning, critical
	input  wire logic                         pllLocked,     // pin: reference PLL synchronised
	input  wire logic                         measCorrupt,   // pin: measurement data corrupt
	input  wire logic                         zeroInvalid,   // pin: zero correction stale
	input  wire logic                         zeroFailed,    // pin: zeroing failed
	input  wire logic                         postFailed,    // pin: power-up self test failed
	input  wire logic                         reference_source_select, // 1 = external reference
	input  wire logic                         cmdValid,      // command strobe
	input  wire logic                         cmdLegacy,     // command came on legacy channel
	input  wire logic                         cmdIsSetting,  // command is a setting, not a query
	input  wire logic                         legacyClose,   // legacy channel closed
	input  wire logic                         opcReceived,   // operation-complete command seen
	input  wire logic                         allDone,       // every earlier command finished
	input  wire logic                         queryErr,      // read without query or unread data
	input  wire logic                         manualReq,     // switched to manual control
	input  wire logic                         errReport,     // parser reports an error
	input  wire sssrb_pkg::sssrb_err_t        errClass,      // class of that error
	input  wire logic [15:0]                  errCodeIn,     // its code
	input  wire logic                         rdReq,         // register query strobe
	input  wire sssrb_pkg::sssrb_sel_t        rdSel,         // which register
	input  wire logic                         rdCond,        // 1 = condition view
	input  wire logic                         maskWr,        // write event mask
	input  wire logic                         qenaWr,        // write questionable enable
	input  wire logic [15:0]                  wrData,        // write data
	output logic [15:0]                       rdData_r,      // query answer
	output logic                              rdValid_r,     // answer valid pulse
	output logic                              cmdAccept_r,   // command accepted pulse
	output logic                              cmdReject_r,   // command refused pulse
	output logic                              errValid_r,    // error code to queue pulse
	output logic [15:0]                       errCode_r,     // error code
	output logic                              ledRed_r,      // red status indicator
	output logic                              standard_event_summary_r, // status byte bit 5
	output logic                              quesSummary_r  // status byte bit 3
);
	import sssrb_pkg::*;

	if (SLOW_CYC < 1 || FAST_CYC < 1 || SLOW_CYC >= (1 << LED_CNT_W) || FAST_CYC >= (1 << LED_CNT_W)) begin : g_bad_led
		$error("flash period does not fit counter");
	end

	// whole module state
	typedef struct packed {
		logic [SYNC_W-1:0]    sync1;      // first synchroniser stage
		logic [SYNC_W-1:0]    sync2;      // second synchroniser stage
		logic                 legacyLock; // legacy channel owns settings
		logic                 opcPending; // operation complete awaited
		logic [EVT_W-1:0]     sevLatch;   // standard event latch
		logic [EVT_W-1:0]     sevMask;    // standard event mask
		logic [REG_W-1:0]     qena;       // questionable enable
		sssrb_led_t           ledPat;     // indicator pattern
		logic [LED_CNT_W-1:0] ledCnt;     // flash counter
		logic                 ledRed;
		logic [REG_W-1:0]     rdData;
		logic                 rdValid;
		logic                 cmdAccept;
		logic                 cmdReject;
		logic                 errValid;
		logic [15:0]          errCode;
		logic                 sevSum;
		logic                 quesSum;
		logic [1:0]           age;        // cycles since reset, saturating
	} sssrb_top_t;

	sssrb_top_t st_r;   // registered state
	sssrb_top_t st_nxt; // next state

	sssrb_reg_if #(.W(REG_W)) devIf  ();  // device status
	sssrb_reg_if #(.W(REG_W)) quesIf ();  // questionable
	sssrb_reg_if #(.W(REG_W)) qpowIf ();  // questionable power
	sssrb_reg_if #(.W(REG_W)) qcalIf ();  // questionable zeroing

	logic [SYNC_W-1:0] pinRaw;  // pins gathered for synchronising
	logic              reject;  // setting refused under legacy lock
	logic              pllOk;   // reference lock as reported
	logic              isEvtRd; // query targets an event view

	assign pinRaw = {postFailed, zeroFailed, zeroInvalid, measCorrupt, pllLocked, staticFault};

	// legacy refusal: setting from a non-legacy channel while locked
	assign reject  = cmdValid && cmdIsSetting && !cmdLegacy && st_r.legacyLock;
	// internal reference always reports locked
	assign pllOk   = !reference_source_select || st_r.sync2[PIN_PLL];
	assign isEvtRd = rdReq && !rdCond;

	// device condition view, undefined bits tied low
	always_comb begin
		devIf.cond                = '0;
		devIf.cond[DEV_NOMEAS]    = st_r.sync2[PIN_FAULT0];
		devIf.cond[DEV_ERRONEOUS] = st_r.sync2[PIN_FAULT0 + 1];
		devIf.cond[DEV_WARN]      = st_r.sync2[PIN_FAULT0 + 2];
		devIf.cond[DEV_CRIT]      = st_r.sync2[PIN_FAULT0 + 3];
		devIf.cond[DEV_SUM]       = |st_r.sync2[PIN_FAULT0 +: 4];
		devIf.cond[DEV_LEGACY]    = st_r.legacyLock;
		devIf.cond[DEV_PLL]       = pllOk;
	end

	// questionable family condition views
	always_comb begin
		qpowIf.cond                = '0;
		qpowIf.cond[QPOW_CORRUPT]  = st_r.sync2[PIN_CORRUPT];
		qpowIf.cond[QPOW_ZERONEED] = st_r.sync2[PIN_ZINV];
		qcalIf.cond                = '0;
		qcalIf.cond[QCAL_FAIL]     = st_r.sync2[PIN_ZFAIL];
		quesIf.cond                = '0;
		quesIf.cond[QUES_POWER]    = |qpowIf.evt;
		quesIf.cond[QUES_ZERO]     = |qcalIf.evt;
		quesIf.cond[QUES_POST]     = st_r.sync2[PIN_POST];
	end

	// event-view reads clear the chosen latch
	assign devIf.rdEvt  = isEvtRd && rdSel == SEL_DEV;
	assign quesIf.rdEvt = isEvtRd && rdSel == SEL_QUES;
	assign qpowIf.rdEvt = isEvtRd && rdSel == SEL_QPOW;
	assign qcalIf.rdEvt = isEvtRd && rdSel == SEL_QCAL;

	sssrb_evt_latch #(.W(REG_W)) u_dev (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.port    (devIf)
	);
	sssrb_evt_latch #(.W(REG_W)) u_ques (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.port    (quesIf)
	);
	sssrb_evt_latch #(.W(REG_W)) u_qpow (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.port    (qpowIf)
	);
	sssrb_evt_latch #(.W(REG_W)) u_qcal (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.port    (qcalIf)
	);

	// next-state logic for the whole bank
	always_comb begin
		st_nxt           = st_r;
		st_nxt.sync1     = pinRaw;
		st_nxt.sync2     = st_r.sync1;
		st_nxt.age       = (st_r.age == 2'h3) ? st_r.age : st_r.age + 2'h1;
		st_nxt.cmdAccept = 1'b0;
		st_nxt.cmdReject = 1'b0;
		st_nxt.errValid  = 1'b0;
		st_nxt.rdValid   = 1'b0;

		// legacy lock: a legacy setting command wins over a close in the same cycle
		if (legacyClose) begin
			st_nxt.legacyLock = 1'b0;
		end
		if (cmdValid && cmdIsSetting && cmdLegacy) begin
			st_nxt.legacyLock = 1'b1;
		end
		// command outcome
		if (reject) begin
			st_nxt.cmdReject = 1'b1;
		end else if (cmdValid) begin
			st_nxt.cmdAccept = 1'b1;
		end

		// standard event latch: a read clears, sets in the same cycle survive
		if (rdReq && rdSel == SEL_EVTLATCH) begin
			st_nxt.sevLatch = '0;
		end
		if (opcReceived) begin
			st_nxt.opcPending = 1'b1;
		end
		if ((st_r.opcPending || opcReceived) && allDone) begin
			st_nxt.sevLatch[SEV_OPC] = 1'b1;
			st_nxt.opcPending        = 1'b0;
		end
		if (queryErr) begin
			st_nxt.sevLatch[SEV_QUERY] = 1'b1;
		end
		if (manualReq) begin
			st_nxt.sevLatch[SEV_USER] = 1'b1;
		end
		// error reports; legacy refusal takes the code slot first
		if (reject) begin
			st_nxt.sevLatch[SEV_EXEC] = 1'b1;
			st_nxt.errValid           = 1'b1;
			st_nxt.errCode            = ERR_LEGACY;
		end
		if (errReport) begin
			case (errClass)
				ERR_DEVDEP: st_nxt.sevLatch[SEV_DEVDEP] = 1'b1;
				ERR_EXEC:   st_nxt.sevLatch[SEV_EXEC]   = 1'b1;
				ERR_CMD:    st_nxt.sevLatch[SEV_CMD]    = 1'b1;
				default:    st_nxt.sevLatch[SEV_EXEC]   = 1'b1;
			endcase
			if (!reject) begin
				st_nxt.errValid = 1'b1;
				st_nxt.errCode  = errCodeIn;
			end
		end

		// mask writes
		if (maskWr) begin
			st_nxt.sevMask = wrData[EVT_W-1:0];
		end
		if (qenaWr) begin
			st_nxt.qena = wrData;
		end

		// query answer, narrow registers zero-extended
		if (rdReq) begin
			st_nxt.rdValid = 1'b1;
			case (rdSel)
				SEL_DEV:  st_nxt.rdData = rdCond ? devIf.cond  : devIf.evt;
				SEL_QUES: st_nxt.rdData = rdCond ? quesIf.cond : quesIf.evt;
				SEL_QPOW: st_nxt.rdData = rdCond ? qpowIf.cond : qpowIf.evt;
				SEL_QCAL: st_nxt.rdData = rdCond ? qcalIf.cond : qcalIf.evt;
				SEL_EVTLATCH: st_nxt.rdData = {8'h00, st_r.sevLatch};
				SEL_EVTMASK:  st_nxt.rdData = {8'h00, st_r.sevMask};
				SEL_QENA: st_nxt.rdData = st_r.qena;
				default:  st_nxt.rdData = 16'h0000;
			endcase
		end

		// summaries toward the status byte
		st_nxt.sevSum  = |(st_r.sevLatch & st_r.sevMask);
		st_nxt.quesSum = |(quesIf.evt & st_r.qena);

		// indicator pattern, critical overrides warning
		case (st_r.ledPat)
			LED_OFF, LED_SLOW, LED_FAST: begin
				if (devIf.cond[DEV_CRIT]) begin
					st_nxt.ledPat = LED_FAST;
				end else if (devIf.cond[DEV_WARN]) begin
					st_nxt.ledPat = LED_SLOW;
				end else begin
					st_nxt.ledPat = LED_OFF;
				end
			end
			default: st_nxt.ledPat = LED_OFF;
		endcase
		// flash generator follows the current pattern
		if (st_r.ledPat == LED_OFF) begin
			st_nxt.ledCnt = '0;
			st_nxt.ledRed = 1'b0;
		end else if (st_r.ledCnt >= LED_CNT_W'((st_r.ledPat == LED_FAST) ? FAST_CYC - 1 : SLOW_CYC - 1)) begin
			st_nxt.ledCnt = '0;
			st_nxt.ledRed = !st_r.ledRed;
		end else begin
			st_nxt.ledCnt = st_r.ledCnt + LED_CNT_W'(1);
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r      <= '0;
			st_r.sevLatch <= LATCH_RESET;
			st_r.sevMask  <= MASK_RESET;
			st_r.qena <= QENA_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign rdData_r                 = st_r.rdData;
	assign rdValid_r                = st_r.rdValid;
	assign cmdAccept_r              = st_r.cmdAccept;
	assign cmdReject_r              = st_r.cmdReject;
	assign errValid_r               = st_r.errValid;
	assign errCode_r                = st_r.errCode;
	assign ledRed_r                 = st_r.ledRed;
	assign standard_event_summary_r = st_r.sevSum;
	assign quesSummary_r            = st_r.quesSum;

	// checks next to the logic they guard
	a_dev_sum: assert property (@(posedge sys_clk) disable iff (!resetn)
		devIf.cond[DEV_SUM] == |devIf.cond[DEV_CRIT:DEV_NOMEAS])
		else $error("device summary bit wrong");
	a_erroneous_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
		st_r.age == 2'h3 |-> devIf.cond[DEV_ERRONEOUS] == $past(staticFault[1], 2))
		else $error("erroneous bit not two cycles behind pin");
	a_led_slow: assert property (@(posedge sys_clk) disable iff (!resetn)
		devIf.cond[DEV_WARN] && !devIf.cond[DEV_CRIT] |=> st_r.ledPat == LED_SLOW)
		else $error("warning without slow flash");
	a_led_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
		devIf.cond[DEV_CRIT] |=> st_r.ledPat == LED_FAST)
		else $error("critical without fast flash");
	a_legacy_lock: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmdValid && cmdIsSetting && cmdLegacy |=> devIf.cond[DEV_LEGACY])
		else $error("legacy setting did not lock");
	a_legacy_refuse: assert property (@(posedge sys_clk) disable iff (!resetn)
		reject |=> cmdReject_r && !cmdAccept_r && errValid_r && errCode_r == ERR_LEGACY)
		else $error("locked setting not refused with -200");
	a_pll_internal: assert property (@(posedge sys_clk) disable iff (!resetn)
		st_r.age == 2'h3 |-> devIf.cond[DEV_PLL] == (!reference_source_select || $past(pllLocked, 2)))
		else $error("reference lock bit wrong");
	a_opc_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
		opcReceived && allDone |=> st_r.sevLatch[SEV_OPC])
		else $error("operation complete not latched");
	a_exec_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
		reject ##1 !(rdReq && rdSel == SEL_EVTLATCH) |=> st_r.sevLatch[SEV_EXEC])
		else $error("execution error bit lost");
	a_cmd_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
		errReport && errClass == ERR_CMD |=> st_r.sevLatch[SEV_CMD])
		else $error("command error bit not set");
	a_event_sum: assert property (@(posedge sys_clk) disable iff (!resetn)
		standard_event_summary_r == $past(|(st_r.sevLatch & st_r.sevMask)))
		else $error("event summary mismatch");
	a_ques_sum: assert property (@(posedge sys_clk) disable iff (!resetn)
		quesSummary_r == $past(|(quesIf.evt & st_r.qena)))
		else $error("questionable summary mismatch");
	a_dev_unused: assert property (@(posedge sys_clk) disable iff (!resetn)
		rdReq && rdSel == SEL_DEV |=> rdValid_r && (rdData_r & ~DEV_USED) == 16'h0000)
		else $error("unused device bits read nonzero");

	c_refuse: cover property (@(posedge sys_clk) disable iff (!resetn) reject);
	c_latch_read: cover property (@(posedge sys_clk) disable iff (!resetn)
		rdReq && rdSel == SEL_EVTLATCH && st_r.sevLatch != 8'h00);
	c_led_fast: cover property (@(posedge sys_clk) disable iff (!resetn) st_r.ledPat == LED_FAST && $rose(ledRed_r));
	c_unlock: cover property (@(posedge sys_clk) disable iff (!resetn) st_r.legacyLock ##1 !st_r.legacyLock);
endmodule : sssrb_status_bank

// >>> rtl/sssrb_pkg.sv
/*
 * constants, bit positions, enums and timing for the sensor status reporting bank.
 * assumes a single 50 MHz clock domain and a command parser on the same clock.
 */
//Contract
//- device bit 0 ORs static-fault bits 1-4
//- device bit 2 marks possibly wrong result
//- bit 3 warning, indicator flashes red slowly
//- bit 4 critical, indicator flashes red fast
//- legacy setting command locks, bit 7 set
//- other-channel setting under lock rejected, -200
//- bit 8 PLL lock, internal always 1
//- questionable bit 3 summarises power register
//- questionable bit 8 summarises zeroing register
//- questionable bit 9 flags power-up self-test failure
//- power bit 1 flags corrupt measurement data
//- power bit 5 flags stale zero correction
//- zeroing bit 1 flags failed zeroing
//- event latch readable, enable mask read/write
//- event bit 0 on operation complete
//- event bit 2 on query error
//- event bit 3 on device error, code queued
//- event bit 4 on execution error, code queued
//- event bit 5 on command error, code queued
//- event bit 6 manual, bit 7 power on
//- summary bit 5 from enabled event bits
//- summary bit 3 from enabled questionable events
package sssrb_pkg;
	localparam int REG_W   = 16;                  // status register width
	localparam int EVT_W   = 8;                   // standard event width
	// device status bit positions
	localparam int DEV_SUM       = 0;
	localparam int DEV_NOMEAS    = 1;
	localparam int DEV_ERRONEOUS = 2;
	localparam int DEV_WARN      = 3;
	localparam int DEV_CRIT      = 4;
	localparam int DEV_LEGACY    = 7;
	localparam int DEV_PLL       = 8;
	// questionable bit positions
	localparam int QUES_POWER    = 3;
	localparam int QUES_ZERO     = 8;
	localparam int QUES_POST     = 9;
	localparam int QPOW_CORRUPT  = 1;
	localparam int QPOW_ZERONEED = 5;
	localparam int QCAL_FAIL     = 1;
	// standard event bit positions
	localparam int SEV_OPC    = 0;
	localparam int SEV_QUERY  = 2;
	localparam int SEV_DEVDEP = 3;
	localparam int SEV_EXEC   = 4;
	localparam int SEV_CMD    = 5;
	localparam int SEV_USER   = 6;
	localparam int SEV_PON    = 7;
	// reset values
	localparam logic [7:0]  LATCH_RESET = 8'h80;  // power-on bit set out of reset
	localparam logic [7:0]  MASK_RESET  = 8'h00;
	localparam logic [15:0] QENA_RESET = 16'h0000;
	localparam logic [15:0] DEV_USED   = 16'h019F; // defined device bits
	localparam logic [15:0] ERR_LEGACY = 16'hFF38; // -200, legacy lock refusal
	// synchroniser lanes for pin inputs
	localparam int SYNC_W     = 9;
	localparam int PIN_FAULT0 = 0;                // four static faults, lanes 0..3
	localparam int PIN_PLL    = 4;
	localparam int PIN_CORRUPT = 5;
	localparam int PIN_ZINV   = 6;
	localparam int PIN_ZFAIL  = 7;
	localparam int PIN_POST   = 8;
	// indicator timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SLOW_HALF_MS  = 500;           // slow flash half period
	localparam int FAST_HALF_MS  = 100;           // fast flash half period
	localparam int SLOW_HALF_CYC = SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int FAST_HALF_CYC = FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int LED_CNT_W     = 26;
	// register selection for queries
	typedef enum logic [2:0] {SEL_DEV, SEL_QUES, SEL_QPOW, SEL_QCAL, SEL_EVTLATCH, SEL_EVTMASK, SEL_QENA} sssrb_sel_t;
	// class of a reported error
	typedef enum logic [1:0] {ERR_DEVDEP, ERR_EXEC, ERR_CMD} sssrb_err_t;
	// indicator pattern
	typedef enum logic [1:0] {LED_OFF, LED_SLOW, LED_FAST} sssrb_led_t;
endpackage : sssrb_pkg

// >>> rtl/sssrb_reg_if.sv
/*
 * carrier between the bank and one condition/event register pair.
 * assumes both ends sit on the bank clock.
 */
`timescale 1ns/100ps
interface sssrb_reg_if #(parameter int W = 16);
	logic [W-1:0] cond;   // live condition bits
	logic         rdEvt;  // event view read, clears it
	logic [W-1:0] evt;    // latched events
	modport latch (input cond, input rdEvt, output evt);
	modport owner (output cond, output rdEvt, input evt);
endinterface : sssrb_reg_if

// >>> rtl/sssrb_evt_latch.sv
/*
 * one condition/event pair: rising condition bits latch, a read clears.
 * assumes the owner drives cond and rdEvt from the same clock.
 */
`timescale 1ns/100ps
module sssrb_evt_latch #(
	parameter int W = 16
) (
	input wire logic sys_clk,
	input wire logic resetn,
	sssrb_reg_if.latch port
);
	import sssrb_pkg::*;

	// state: previous condition and latched events
	typedef struct packed {
		logic [W-1:0] prevCond;
		logic [W-1:0] evt;
	} sssrb_latch_t;

	sssrb_latch_t st_r;   // registered state
	sssrb_latch_t st_nxt; // next state

	if (W < 1 || W > REG_W) begin : g_bad_w
		$error("latch width out of range");
	end

	// rising bits set, a read clears, a set in the read cycle survives
	always_comb begin
		st_nxt          = st_r;
		st_nxt.prevCond = port.cond;
		st_nxt.evt      = (port.rdEvt ? '0 : st_r.evt) | (port.cond & ~st_r.prevCond);
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign port.evt = st_r.evt;

	a_read_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
		port.rdEvt && ((port.cond & ~st_r.prevCond) == '0) |=> port.evt == '0)
		else $error("event view not cleared by read");
endmodule : sssrb_evt_latch

// >>> tb/sssrb_ctrl_model.sv
/*
 * controller model: issues commands, error strobes, mask writes and register queries.
 * assumes the bank takes requests on the rising sys_clk edge and answers one edge later.
 */
`timescale 1ns/100ps
module sssrb_ctrl_model
	import sssrb_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic [15:0]           rdData_r,
	output logic [7:0]                 stb,     // cmd,opc,qerr,manual,err,close,mask,qena
	output logic                       cmdLegacy,
	output logic                       cmdIsSetting,
	output logic                       allDone,
	output sssrb_pkg::sssrb_err_t      errClass,
	output logic [15:0]                errCodeIn,
	output logic [15:0]                wrData,
	output logic                       rdReq,
	output sssrb_pkg::sssrb_sel_t      rdSel,
	output logic                       rdCond
);
	import sssrb_pkg::*;
	// idle controller at time zero
	initial begin
		stb = 8'h00;
		{cmdLegacy, cmdIsSetting, rdReq, rdCond} = 4'h0;
		allDone = 1'b1;
		errClass = ERR_EXEC;
		{errCodeIn, wrData} = 32'h0;
		rdSel = SEL_DEV;
	end
	// one request, held over its taking edge; bit 5 closes the legacy channel
	task automatic kick(input logic [7:0] m, input logic lg, input logic st, input logic [15:0] v,
		input sssrb_err_t c);
		@(posedge sys_clk) #1;
		stb = m;
		cmdLegacy = lg;
		cmdIsSetting = st;
		errCodeIn = v;
		wrData = v;
		errClass = c;
		@(posedge sys_clk) #1;
		stb = 8'h00;
	endtask : kick
	// query: answer taken one edge after the request
	task automatic rd(input sssrb_sel_t s, input logic c, output logic [15:0] d);
		@(posedge sys_clk) #1;
		rdReq = 1'b1;
		rdSel = s;
		rdCond = c;
		@(posedge sys_clk) #1;
		rdReq = 1'b0;
		d = rdData_r;
	endtask : rd
endmodule : sssrb_ctrl_model

// >>> tb/tb.sv
/*
 * testbench: pins and controller model around the status bank, self-checking.
 * assumes small flash counts (8 and 3 cycles) and a 50 MHz clock.
 */
`timescale 1ns/100ps
module tb;
	import sssrb_pkg::*;
	logic              sys_clk = 1'b0;
	logic              resetn = 1'b0;
	logic [3:0]        staticFault = 4'h0;
	logic              pllLocked = 1'b0, measCorrupt = 1'b0, zeroInvalid = 1'b0;
	logic              zeroFailed = 1'b0, postFailed = 1'b0, refExt = 1'b0;
	logic [7:0]        stb;
	logic              cmdLegacy, cmdIsSetting, allDone, rdReq, rdCond;
	sssrb_err_t        errClass;
	sssrb_sel_t        rdSel;
	logic [15:0]       errCodeIn, wrData, rdData_r, errCode_r;
	logic              rdValid_r, cmdAccept_r, cmdReject_r, errValid_r, ledRed_r;
	logic              standard_event_summary_r, quesSummary_r;
	int                err_total = 0;
	int                comparisons = 0;
	// 20 ns clock
	always #10 sys_clk = ~sys_clk;
	sssrb_status_bank #(.SLOW_CYC(8), .FAST_CYC(3)) uut (.sys_clk, .resetn, .staticFault, .pllLocked,
		.measCorrupt, .zeroInvalid, .zeroFailed, .postFailed, .reference_source_select(refExt),
		.cmdValid(stb[0]), .cmdLegacy, .cmdIsSetting, .legacyClose(stb[5]), .opcReceived(stb[1]),
		.allDone, .queryErr(stb[2]), .manualReq(stb[3]), .errReport(stb[4]), .errClass, .errCodeIn,
		.rdReq, .rdSel, .rdCond, .maskWr(stb[6]), .qenaWr(stb[7]), .wrData, .rdData_r, .rdValid_r,
		.cmdAccept_r, .cmdReject_r, .errValid_r, .errCode_r, .ledRed_r, .standard_event_summary_r,
		.quesSummary_r);
	sssrb_ctrl_model m (.sys_clk, .rdData_r, .stb, .cmdLegacy, .cmdIsSetting, .allDone, .errClass,
		.errCodeIn, .wrData, .rdReq, .rdSel, .rdCond);
	// compare and count
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// counts, verdict, end of run
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	// hang guard
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
	// main sequence
	initial begin
		logic [15:0] d;
		repeat (2) @(posedge sys_clk);
		#1 resetn = 1'b1;
		m.rd(SEL_EVTLATCH, 1'b0, d); chk("latch pon", d, 16'h0080);
		chk("rd valid", rdValid_r, 1);
		m.rd(SEL_EVTLATCH, 1'b0, d); chk("latch clr", d, 16'h0000);
		staticFault = 4'b0010;
		refExt = 1'b1;
		repeat (4) @(posedge sys_clk);
		m.rd(SEL_DEV, 1'b1, d); chk("dev ext", d, 16'h0005);
		pllLocked = 1'b1;
		staticFault = 4'b1100;
		repeat (4) @(posedge sys_clk);
		m.rd(SEL_DEV, 1'b1, d); chk("dev sync", d, 16'h0119);
		d[0] = ledRed_r;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("led", ledRed_r, {15'h0, ~d[0]});
		// internal reference from here on, lock pin low
		{refExt, pllLocked} = 2'b00;
		// legacy lock, refusal, unlock
		m.kick(8'h01, 1'b1, 1'b1, 16'h0, ERR_EXEC); chk("acc", cmdAccept_r, 1);
		m.rd(SEL_DEV, 1'b1, d); chk("dev lock", d, 16'h0199);
		m.kick(8'h01, 1'b0, 1'b1, 16'h0, ERR_EXEC); chk("rej", cmdReject_r, 1);
		chk("rej code", errCode_r, 16'hFF38);
		chk("rej valid", errValid_r, 1);
		m.kick(8'h01, 1'b0, 1'b0, 16'h0, ERR_EXEC); chk("query ok", cmdAccept_r, 1);
		m.kick(8'h20, 1'b0, 1'b0, 16'h0, ERR_EXEC);
		m.kick(8'h01, 1'b0, 1'b1, 16'h0, ERR_EXEC); chk("unlock", cmdAccept_r, 1);
		// every error class, then the single-event strobes together
		for (int i = 0; i < 3; i++) begin
			m.kick(8'h10, 1'b0, 1'b0, 16'(16'hFED4 + 16'h0040 * i), sssrb_err_t'(i));
			chk("code", errCode_r, 16'(16'hFED4 + 16'h0040 * i));
		end
		m.kick(8'h0E, 1'b0, 1'b0, 16'h0, ERR_EXEC);
		m.kick(8'h40, 1'b0, 1'b0, 16'h0020, ERR_EXEC);
		@(posedge sys_clk) #1;
		chk("summary on", standard_event_summary_r, 1);
		m.rd(SEL_EVTMASK, 1'b0, d); chk("mask", d, 16'h0020);
		m.rd(SEL_EVTLATCH, 1'b0, d); chk("latch", d, 16'h007D);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("summary off", standard_event_summary_r, 0);
		// questionable tree
		{measCorrupt, zeroInvalid, zeroFailed, postFailed} = 4'hF;
		m.kick(8'h80, 1'b0, 1'b0, 16'h0008, ERR_EXEC);
		repeat (8) @(posedge sys_clk);
		#1;
		chk("ques sum", quesSummary_r, 1);
		m.rd(SEL_QENA, 1'b0, d); chk("qena", d, 16'h0008);
		m.rd(SEL_QUES, 1'b1, d); chk("ques", d, 16'h0308);
		m.rd(SEL_QPOW, 1'b1, d); chk("qpow", d, 16'h0022);
		m.rd(SEL_QCAL, 1'b1, d); chk("qcal", d, 16'h0002);
		m.rd(SEL_QPOW, 1'b0, d); chk("qpow evt", d, 16'h0022);
		m.rd(SEL_QPOW, 1'b0, d); chk("qpow clr", d, 16'h0000);
		m.rd(SEL_DEV, 1'b0, d); chk("dev evt", d, 16'h019D);
		give_verdict();
	end
endmodule : tb
